// file: logic/serial_quad_fifo_descriptor_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - transmit starts when fifo reaches transmit threshold
// - receive fetches enough bytes to fill fifo to receive threshold
// - no receive unless fifo has room
// - fifo reads trigger refill up to threshold
// - boot or xip fetches use bus burst
// - enables for dma error, packet, done, threshold
// - low six enables cover fifo events
// - full 32-bit root descriptor address register
// - read-only descriptor processor state field
// - status bit shows dma started
// - status bit shows processor active
// - low half shows current descriptor control
// - unimplemented bits read zero, ignore writes
module serial_quad_fifo_descriptor_ctrl #(
  parameter int FIFO_DEPTH = serial_quad_pkg::FIFO_DEPTH_DEF,
  parameter int CNT_W      = serial_quad_pkg::CNT_W_DEF
) (
  // clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // register bus
  input  wire logic [7:0]                  address_i,
  input  wire logic                        read_i,
  input  wire logic                        write_i,
  input  wire logic [3:0]                  byteenable_i,
  input  wire logic [31:0]                 writedata_i,
  output logic      [31:0]                 readdata_o,
  output logic                             waitrequest_o,
  output logic                             irq_o,
  // fifo levels and initiation mode
  input  wire serial_quad_pkg::init_mode_e init_mode_i,
  input  wire logic [CNT_W-1:0]            tx_fifo_count_i,
  input  wire logic [CNT_W-1:0]            rx_fifo_count_i,
  input  wire logic [CNT_W-1:0]            bus_burst_bytes_i,
  // flash link clock
  input  wire logic                        link_clk_i,
  // transfer control
  output logic                             tx_start_o,
  output logic                             rx_start_o,
  output logic                             xfer_busy_o,
  output logic                             xfer_done_o,
  output logic      [CNT_W-1:0]            xfer_len_o,
  // descriptor dma
  input  wire logic                        dma_bus_error_i,
  input  wire logic                        packet_complete_i,
  input  wire logic                        descriptor_done_i,
  input  wire logic                        control_threshold_i,
  input  wire logic                        control_empty_i,
  input  wire logic                        control_full_i,
  input  wire logic [3:0]                  descriptor_processor_state_i,
  input  wire logic                        dma_started_i,
  input  wire logic                        descriptor_processor_active_i,
  input  wire logic [15:0]                 current_descriptor_control_i,
  output logic      [31:0]                 root_descriptor_address_o
);

  // ************************************************************
  // state
  // ************************************************************
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(FIFO_DEPTH);

  typedef struct packed {
    logic                              ack;
    logic [31:0]                       rdata;
    logic [serial_quad_pkg::THR_W-1:0] thr_tx;
    logic [serial_quad_pkg::THR_W-1:0] thr_rx;
    logic [serial_quad_pkg::INT_W-1:0] int_en;
    logic [serial_quad_pkg::INT_W-1:0] int_stat;
    logic [31:0]                       bd_base;
    logic [serial_quad_pkg::LVL_W-1:0] lvl_prev;
    logic                              sck_prev;
    serial_quad_pkg::xfer_state_e      xstate;
    logic [2:0]                        bit_cnt;
    logic [CNT_W-1:0]                  bytes_left;
    logic [CNT_W-1:0]                  xfer_len;
    logic                              tx_start;
    logic                              rx_start;
    logic                              done;
  } state_s;

  state_s st;
  state_s next_st;

  logic                              sck_s;
  logic [CNT_W-1:0]                  rx_free;
  logic [CNT_W-1:0]                  thr_tx_c;
  logic [CNT_W-1:0]                  thr_rx_c;
  logic [serial_quad_pkg::LVL_W-1:0] lvl;
  logic [serial_quad_pkg::INT_W-1:0] events;
  logic [serial_quad_pkg::INT_W-1:0] clr;
  logic [31:0]                       rd_mux;
  logic [31:0]                       wr_merged;
  logic                              tx_go;
  logic                              rx_go;
  logic                              xip_go;

  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be
  );
    logic [31:0] r;
    r = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge_lanes

  // ************************************************************
  // link clock synchroniser
  // ************************************************************
  link_sync #(
    .W       (1)
  ) u_link_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (link_clk_i),
    .sync_o  (sck_s)
  );

  // ************************************************************
  // fifo conditions
  // ************************************************************
  assign rx_free  = DEPTH_C - rx_fifo_count_i;
  assign thr_tx_c = CNT_W'(st.thr_tx);
  assign thr_rx_c = CNT_W'(st.thr_rx);

  // start conditions, only taken while no transfer runs
  assign tx_go  = (init_mode_i == serial_quad_pkg::MODE_TRANSMIT) &&
                  (tx_fifo_count_i >= thr_tx_c) &&
                  (tx_fifo_count_i != '0);
  assign rx_go  = (init_mode_i == serial_quad_pkg::MODE_RECEIVE) &&
                  (rx_fifo_count_i < thr_rx_c) &&
                  (rx_free >= thr_rx_c);
  assign xip_go = (init_mode_i == serial_quad_pkg::MODE_BOOT_XIP) &&
                  (rx_fifo_count_i == '0) &&
                  (bus_burst_bytes_i != '0) &&
                  (rx_free >= bus_burst_bytes_i);

  // level conditions turned into events on their rising edge
  assign lvl = {rx_fifo_count_i >= thr_rx_c,
                rx_fifo_count_i == DEPTH_C,
                rx_fifo_count_i == '0,
                tx_fifo_count_i >= thr_tx_c,
                tx_fifo_count_i == DEPTH_C,
                tx_fifo_count_i == '0};

  assign events = {dma_bus_error_i, packet_complete_i, descriptor_done_i,
                   control_threshold_i, control_empty_i, control_full_i,
                   lvl & ~st.lvl_prev};

  // ************************************************************
  // register read mux
  // ************************************************************
  always_comb begin
    rd_mux = 32'h00000000;
    case (address_i)
      serial_quad_pkg::OFF_CMD_THR: begin
        rd_mux[serial_quad_pkg::TX_THR_LSB +: serial_quad_pkg::THR_W] =
          st.thr_tx;
        rd_mux[serial_quad_pkg::RX_THR_LSB +: serial_quad_pkg::THR_W] =
          st.thr_rx;
      end
      serial_quad_pkg::OFF_INT_EN: begin
        rd_mux[serial_quad_pkg::INT_W-1:0] = st.int_en;
      end
      serial_quad_pkg::OFF_BD_BASE: begin
        rd_mux = st.bd_base;
      end
      serial_quad_pkg::OFF_BD_STAT: begin
        rd_mux[serial_quad_pkg::BD_STATE_LSB +: serial_quad_pkg::BD_STATE_W]
          = descriptor_processor_state_i;
        rd_mux[serial_quad_pkg::DMA_STARTED_BIT] = dma_started_i;
        rd_mux[serial_quad_pkg::BDP_ACTIVE_BIT] =
          descriptor_processor_active_i;
        rd_mux[serial_quad_pkg::BD_CON_W-1:0] =
          current_descriptor_control_i;
      end
      serial_quad_pkg::OFF_INT_STAT: begin
        rd_mux[serial_quad_pkg::INT_W-1:0] = st.int_stat;
      end
      serial_quad_pkg::OFF_XFER_STAT: begin
        rd_mux[serial_quad_pkg::XS_BUSY_BIT] =
          (st.xstate != serial_quad_pkg::XFER_IDLE);
        rd_mux[serial_quad_pkg::XS_RX_BIT] =
          (st.xstate == serial_quad_pkg::XFER_RX);
        rd_mux[serial_quad_pkg::XS_LEN_LSB +: CNT_W] = st.xfer_len;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st          = st;
    next_st.tx_start = 1'b0;
    next_st.rx_start = 1'b0;
    next_st.done     = 1'b0;
    wr_merged        = merge_lanes(32'h00000000, writedata_i, byteenable_i);
    clr              = '0;

    // bus: one wait cycle, answer on the second
    next_st.ack = (read_i | write_i) & ~st.ack;
    if (read_i && !st.ack) begin
      next_st.rdata = rd_mux;
    end
    if (write_i && st.ack) begin
      case (address_i)
        serial_quad_pkg::OFF_CMD_THR: begin
          wr_merged = merge_lanes(rd_mux, writedata_i, byteenable_i);
          next_st.thr_tx =
            wr_merged[serial_quad_pkg::TX_THR_LSB +: serial_quad_pkg::THR_W];
          next_st.thr_rx =
            wr_merged[serial_quad_pkg::RX_THR_LSB +: serial_quad_pkg::THR_W];
        end
        serial_quad_pkg::OFF_INT_EN: begin
          wr_merged = merge_lanes(rd_mux, writedata_i, byteenable_i);
          next_st.int_en = wr_merged[serial_quad_pkg::INT_W-1:0];
        end
        serial_quad_pkg::OFF_BD_BASE: begin
          wr_merged = merge_lanes(st.bd_base, writedata_i, byteenable_i);
          next_st.bd_base = wr_merged;
        end
        default: begin
          wr_merged = 32'h00000000;
        end
      endcase
    end

    // sticky flags: read clears what was reported, a new event wins
    if (read_i && st.ack && address_i == serial_quad_pkg::OFF_INT_STAT) begin
      clr = st.rdata[serial_quad_pkg::INT_W-1:0];
    end
    next_st.int_stat = (st.int_stat & ~clr) | events;
    next_st.lvl_prev = lvl;

    // transfer engine paced by link clock rising edges
    next_st.sck_prev = sck_s;
    unique case (st.xstate)
      serial_quad_pkg::XFER_IDLE: begin
        next_st.bit_cnt = 3'h0;
        if (tx_go) begin
          next_st.xstate     = serial_quad_pkg::XFER_TX;
          next_st.xfer_len   = tx_fifo_count_i;
          next_st.bytes_left = tx_fifo_count_i;
          next_st.tx_start   = 1'b1;
        end else if (rx_go) begin
          next_st.xstate     = serial_quad_pkg::XFER_RX;
          next_st.xfer_len   = thr_rx_c - rx_fifo_count_i;
          next_st.bytes_left = thr_rx_c - rx_fifo_count_i;
          next_st.rx_start   = 1'b1;
        end else if (xip_go) begin
          next_st.xstate     = serial_quad_pkg::XFER_RX;
          next_st.xfer_len   = bus_burst_bytes_i;
          next_st.bytes_left = bus_burst_bytes_i;
          next_st.rx_start   = 1'b1;
        end
      end
      serial_quad_pkg::XFER_TX,
      serial_quad_pkg::XFER_RX: begin
        if (sck_s && !st.sck_prev) begin
          next_st.bit_cnt = st.bit_cnt + 3'h1;
          if (st.bit_cnt == serial_quad_pkg::LAST_BIT) begin
            next_st.bytes_left = st.bytes_left - CNT_W'(1);
            if (st.bytes_left == CNT_W'(1)) begin
              next_st.xstate = serial_quad_pkg::XFER_IDLE;
              next_st.done   = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign readdata_o                = st.rdata;
  assign waitrequest_o             = (read_i | write_i) & ~st.ack;
  assign irq_o                     = |(st.int_stat & st.int_en);
  assign tx_start_o                = st.tx_start;
  assign rx_start_o                = st.rx_start;
  assign xfer_busy_o               = (st.xstate != serial_quad_pkg::XFER_IDLE);
  assign xfer_done_o               = st.done;
  assign xfer_len_o                = st.xfer_len;
  assign root_descriptor_address_o = st.bd_base;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_tx_start;
    tx_start_o |-> $past(init_mode_i) == serial_quad_pkg::MODE_TRANSMIT &&
      int'($past(tx_fifo_count_i)) >= int'($past(st.thr_tx)) &&
      xfer_len_o == $past(tx_fifo_count_i);
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("transmit started below threshold");

  property p_rx_len;
    rx_start_o && $past(init_mode_i) == serial_quad_pkg::MODE_RECEIVE |->
      int'(xfer_len_o) + int'($past(rx_fifo_count_i)) ==
      int'($past(st.thr_rx));
  endproperty
  a_rx_len: assert property (p_rx_len)
    else $error("receive length does not fill to threshold");

  property p_rx_room;
    rx_start_o && $past(init_mode_i) == serial_quad_pkg::MODE_RECEIVE |->
      FIFO_DEPTH - int'($past(rx_fifo_count_i)) >= int'($past(st.thr_rx));
  endproperty
  a_rx_room: assert property (p_rx_room)
    else $error("receive started without room");

  property p_refill;
    !xfer_busy_o && rx_go |=> rx_start_o ##1 xfer_busy_o;
  endproperty
  a_refill: assert property (p_refill)
    else $error("receive refill not started");

  property p_xip_len;
    rx_start_o && $past(init_mode_i) == serial_quad_pkg::MODE_BOOT_XIP |->
      xfer_len_o == $past(bus_burst_bytes_i);
  endproperty
  a_xip_len: assert property (p_xip_len)
    else $error("boot fetch not sized by burst");

  property p_int_en_write;
    write_i && !waitrequest_o && address_i == serial_quad_pkg::OFF_INT_EN &&
      byteenable_i == 4'hF |=>
      {20'h00000, st.int_en} == ($past(writedata_i) &
      serial_quad_pkg::INT_EN_MASK);
  endproperty
  a_int_en_write: assert property (p_int_en_write)
    else $error("interrupt enable write lost");

  property p_thr_zero;
    read_i && !waitrequest_o && address_i == serial_quad_pkg::OFF_CMD_THR |->
      (readdata_o & ~serial_quad_pkg::THR_MASK) == 32'h00000000;
  endproperty
  a_thr_zero: assert property (p_thr_zero)
    else $error("unimplemented threshold bits not zero");

  property p_base_write;
    write_i && !waitrequest_o && address_i == serial_quad_pkg::OFF_BD_BASE &&
      byteenable_i == 4'hF |=>
      root_descriptor_address_o == $past(writedata_i);
  endproperty
  a_base_write: assert property (p_base_write)
    else $error("descriptor base write lost");

  property p_bd_stat;
    read_i && waitrequest_o && address_i == serial_quad_pkg::OFF_BD_STAT |=>
      readdata_o == {10'h000, $past(descriptor_processor_state_i),
      $past(dma_started_i), $past(descriptor_processor_active_i),
      $past(current_descriptor_control_i)};
  endproperty
  a_bd_stat: assert property (p_bd_stat)
    else $error("descriptor status read wrong");

  property p_irq;
    (events & st.int_en) != '0 && !(write_i && st.ack) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event gave no interrupt");

endmodule : serial_quad_fifo_descriptor_ctrl
`default_nettype wire

// file: common/serial_quad_pkg.sv
`default_nettype none
package serial_quad_pkg;

  // ************************************************************
  // register byte offsets
  // ************************************************************
  localparam logic [7:0] OFF_CMD_THR   = 8'h00;
  localparam logic [7:0] OFF_INT_EN    = 8'h04;
  localparam logic [7:0] OFF_BD_BASE   = 8'h08;
  localparam logic [7:0] OFF_BD_STAT   = 8'h0C;
  localparam logic [7:0] OFF_INT_STAT  = 8'h10;
  localparam logic [7:0] OFF_XFER_STAT = 8'h14;

  // ************************************************************
  // field positions and widths
  // ************************************************************
  localparam int THR_W           = 5;
  localparam int TX_THR_LSB      = 8;
  localparam int RX_THR_LSB      = 0;
  localparam int INT_W           = 12;
  localparam int BD_STATE_LSB    = 18;
  localparam int BD_STATE_W      = 4;
  localparam int DMA_STARTED_BIT = 17;
  localparam int BDP_ACTIVE_BIT  = 16;
  localparam int BD_CON_W        = 16;
  localparam int XS_BUSY_BIT     = 0;
  localparam int XS_RX_BIT       = 1;
  localparam int XS_LEN_LSB      = 8;
  localparam int LVL_W           = 6;

  // ************************************************************
  // reset values and masks
  // ************************************************************
  localparam logic [THR_W-1:0] THR_RST     = 5'h00;
  localparam logic [INT_W-1:0] INT_EN_RST  = 12'h000;
  localparam logic [31:0]      BD_BASE_RST = 32'h00000000;
  localparam logic [31:0]      INT_EN_MASK = 32'h00000FFF;
  localparam logic [31:0]      THR_MASK    = 32'h00001F1F;

  // ************************************************************
  // timing and sizes
  // ************************************************************
  localparam logic [2:0] LAST_BIT      = 3'h7;
  localparam int         FIFO_DEPTH_DEF = 32;
  localparam int         CNT_W_DEF      = 6;

  // ************************************************************
  // modes and states
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_TRANSMIT,
    MODE_RECEIVE,
    MODE_BOOT_XIP
  } init_mode_e;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_TX,
    XFER_RX
  } xfer_state_e;

endpackage : serial_quad_pkg
`default_nettype wire

// file: logic/link_sync.sv
`timescale 1ns/1ns
`default_nettype none
module link_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // asynchronous in, synchronous out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } sync_s;

  sync_s st;
  sync_s next_st;

  always_comb begin
    next_st      = st;
    next_st.meta = async_i;
    next_st.sync = st.meta;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.sync;

endmodule : link_sync
`default_nettype wire

// file: test/flash_link_model.sv
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// flash device side: link clock only while a frame runs
// ************************************************************
module flash_link_model (
  // frame window
  input  wire logic busy_i,
  // link clock
  output var logic  link_clk_o
);
  // stands low between frames, phase unrelated to the system clock
  initial begin
    link_clk_o = 1'b0;
    #7;
    forever begin
      #80;
      link_clk_o = busy_i ? ~link_clk_o : 1'b0;
    end
  end
endmodule : flash_link_model
`default_nettype wire

// file: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic                        clk_i = 1'b0;
  logic                        rst_i = 1'b1;
  logic [7:0]                  address_i;
  logic                        read_i;
  logic                        write_i;
  logic [3:0]                  byteenable_i;
  logic [31:0]                 writedata_i;
  logic [31:0]                 readdata_o;
  logic                        waitrequest_o;
  logic                        irq_o;
  serial_quad_pkg::init_mode_e mode;
  logic [5:0]                  txc;
  logic [5:0]                  rxc;
  logic [5:0]                  burst;
  logic                        link_clk;
  logic                        tx_start_o;
  logic                        rx_start_o;
  logic                        xfer_busy_o;
  logic                        xfer_done_o;
  logic [5:0]                  xfer_len_o;
  logic [5:0]                  ev;
  logic [3:0]                  bst;
  logic                        bsa;
  logic                        bac;
  logic [15:0]                 bcon;
  logic [31:0]                 base_o;
  logic [31:0]                 r;
  logic [31:0]                 d;
  int                          errors = 0;
  int                          tests_run = 0;
  int                          seed = 32'hB942;
  int                          m_base;
  int                          t;

  always #10 clk_i = ~clk_i;

  serial_quad_fifo_descriptor_ctrl serial_quad_fifo_descriptor_ctrl_inst (
    .clk_i(clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i),
    .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o), .irq_o(irq_o), .init_mode_i(mode),
    .tx_fifo_count_i(txc), .rx_fifo_count_i(rxc),
    .bus_burst_bytes_i(burst), .link_clk_i(link_clk),
    .tx_start_o(tx_start_o), .rx_start_o(rx_start_o),
    .xfer_busy_o(xfer_busy_o), .xfer_done_o(xfer_done_o),
    .xfer_len_o(xfer_len_o), .dma_bus_error_i(ev[5]),
    .packet_complete_i(ev[4]), .descriptor_done_i(ev[3]),
    .control_threshold_i(ev[2]), .control_empty_i(ev[1]),
    .control_full_i(ev[0]), .descriptor_processor_state_i(bst),
    .dma_started_i(bsa), .descriptor_processor_active_i(bac),
    .current_descriptor_control_i(bcon),
    .root_descriptor_address_o(base_o)
  );

  flash_link_model flash_link_model_inst (
    .busy_i(xfer_busy_o), .link_clk_o(link_clk)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic test_done;
    if (errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic bail;
    errors++;
    $display("unexpected at %0t: wait ran out", $time);
    test_done();
  endtask : bail

  // avalon cycle: hold until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, input logic [3:0] be,
                     output logic [31:0] rd);
    int n;
    n = 0;
    address_i <= a;
    writedata_i <= wd;
    byteenable_i <= be;
    write_i <= wr;
    read_i <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    rd = readdata_o;
    if (n >= 20) bail();
    read_i <= 1'b0;
    write_i <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'hF, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'hF, d);
    check(d, exp);
  endtask : rdchk

  task automatic quiet(input int n);
    logic s;
    s = 1'b0;
    repeat (n) begin
      @(posedge clk_i);
      s = s | tx_start_o | rx_start_o;
    end
    check(32'(s), 32'h0);
  endtask : quiet

  // waits for a start, checks length, then runs the frame to done
  task automatic xfer(input logic rx, input int len, input int nc);
    int n;
    n = 0;
    while ((rx ? rx_start_o : tx_start_o) !== 1'b1 && n < 40) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 40) bail();
    check(32'({xfer_busy_o, xfer_len_o}), 32'({1'b1, 6'(len)}));
    if (rx) rxc <= 6'(nc);
    else txc <= 6'(nc);
    n = 0;
    while (xfer_done_o !== 1'b1 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000) bail();
  endtask : xfer

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {address_i, read_i, write_i, byteenable_i, writedata_i} = '0;
    {txc, rxc, burst, ev, bst, bsa, bac, bcon} = '0;
    mode = serial_quad_pkg::MODE_IDLE;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdchk(serial_quad_pkg::OFF_INT_EN, 32'h0);
    rdchk(serial_quad_pkg::OFF_BD_BASE, 32'h0);
    rdchk(8'h20, 32'h0);
    r = $random(seed);
    wr(serial_quad_pkg::OFF_CMD_THR, r);
    rdchk(serial_quad_pkg::OFF_CMD_THR, r & 32'h00001F1F);
    wr(serial_quad_pkg::OFF_INT_EN, r);
    rdchk(serial_quad_pkg::OFF_INT_EN, r & 32'h00000FFF);
    m_base = $random(seed);
    wr(serial_quad_pkg::OFF_BD_BASE, m_base);
    bus(1'b1, serial_quad_pkg::OFF_BD_BASE, 32'hFFFFFFFF, 4'h2, d);
    m_base = m_base | 32'h0000FF00;
    rdchk(serial_quad_pkg::OFF_BD_BASE, m_base);
    check(base_o, m_base);
    for (int s = 0; s < 6; s++) begin
      r = $random(seed);
      bst <= 4'(s);
      {bsa, bac, bcon} <= r[17:0];
      wr(serial_quad_pkg::OFF_BD_STAT, 32'hFFFFFFFF);
      rdchk(serial_quad_pkg::OFF_BD_STAT,
            {10'h0, 4'(s), r[17:0]});
    end
    // each dma event: masked, then unmasked, then cleared by a read
    for (int i = 0; i < 6; i++) begin
      wr(serial_quad_pkg::OFF_INT_EN, 32'h0);
      bus(1'b0, serial_quad_pkg::OFF_INT_STAT, 32'h0, 4'hF, d);
      ev[i] <= 1'b1;
      @(posedge clk_i);
      ev <= '0;
      repeat (3) @(posedge clk_i);
      check(32'(irq_o), 32'h0);
      wr(serial_quad_pkg::OFF_INT_EN, 32'h40 << i);
      check(32'(irq_o), 32'h1);
      bus(1'b0, serial_quad_pkg::OFF_INT_STAT, 32'h0, 4'hF, d);
      check(d & 32'hFC0, 32'h40 << i);
      check(32'(irq_o), 32'h0);
    end
    wr(serial_quad_pkg::OFF_INT_EN, 32'h0);
    t = 1 + ($random(seed) & 15);
    wr(serial_quad_pkg::OFF_CMD_THR, t << 8);
    mode <= serial_quad_pkg::MODE_TRANSMIT;
    txc <= 6'(t - 1);
    quiet(30);
    txc <= 6'(t);
    xfer(1'b0, t, 0);
    mode <= serial_quad_pkg::MODE_IDLE;
    wr(serial_quad_pkg::OFF_CMD_THR, 32'd8);
    mode <= serial_quad_pkg::MODE_RECEIVE;
    xfer(1'b1, 8, 8);
    rdchk(serial_quad_pkg::OFF_XFER_STAT, 32'h00000800);
    // fill reaching the receive threshold is a sticky event
    bus(1'b0, serial_quad_pkg::OFF_INT_STAT, 32'h0, 4'hF, d);
    check(d & 32'h20, 32'h20);
    quiet(30);
    rxc <= 6'd5;
    xfer(1'b1, 3, 8);
    mode <= serial_quad_pkg::MODE_IDLE;
    wr(serial_quad_pkg::OFF_CMD_THR, 32'd20);
    rxc <= 6'd15;
    mode <= serial_quad_pkg::MODE_RECEIVE;
    quiet(30);
    rxc <= 6'd12;
    xfer(1'b1, 8, 20);
    rxc <= 6'd0;
    burst <= 6'd12;
    mode <= serial_quad_pkg::MODE_BOOT_XIP;
    xfer(1'b1, 12, 12);
    mode <= serial_quad_pkg::MODE_IDLE;
    repeat (4) @(posedge clk_i);
    test_done();
  end
endmodule : tb_top
`default_nettype wire
